// ==== src/iom_io_pin_function_mux.sv ====
// Pin mode, drive and function multiplexing plus interrupt source select
//
// Function
// RQ1 - Settings are clocked by the fast system bus clock, not a slow bus.
// RQ2 - Each pin connects at most one peripheral function at a time.
// RQ3 - Each pin has a sixteen-way selector split over low and high halves.
// RQ4 - After reset every pin selector points at input zero.
// RQ5 - Peripherals are reached only through selector values one to thirteen.
// RQ6 - Selector value fifteen connects the core event output to the pin.
// RQ7 - In alternate mode the connected peripheral decides the pin direction.
// RQ8 - Software sets mode, then type, pull, speed, then the selector.
// RQ9 - Output type, pull and speed are separate per-pin settings.
// RQ10 - One peripheral signal may appear on several pins via their selectors.
// RQ11 - A per-line field picks which port feeds each interrupt line.
// RQ12 - Interrupt source codes above 0101 are invalid; six ports.
// RQ13 - Push-pull or open-drain with any pull; input pulls; analog mode.
// RQ14 - Output speed is a two-bit code with four levels.
`timescale 1ns/1ns
module iom_io_pin_function_mux #(
  parameter int NUM_PINS = 16,
  parameter int NUM_IRQ_LINES = 16,
  parameter int NUM_PORTS = 6
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2*NUM_PINS-1:0] pin_mode_setting,
  input wire logic [NUM_PINS-1:0] pin_output_type_setting,
  input wire logic [2*NUM_PINS-1:0] pin_pull_setting,
  input wire logic [2*NUM_PINS-1:0] pin_speed_setting,
  input wire logic [2*NUM_PINS-1:0] func_select_low_half,
  input wire logic [2*NUM_PINS-1:0] func_select_high_half,
  input wire logic [NUM_PINS-1:0] gpio_out,
  input wire logic [iom_pkg::FUNC_COUNT*NUM_PINS-1:0] func_out,
  input wire logic [iom_pkg::FUNC_COUNT*NUM_PINS-1:0] func_oe,
  input wire logic core_event_output,
  input wire logic [NUM_PINS-1:0] pad_in,
  input wire logic [4*NUM_IRQ_LINES-1:0] irq_line_source_select,
  input wire logic [NUM_PORTS*NUM_IRQ_LINES-1:0] port_pins,
  output logic [NUM_PINS-1:0] pad_out_q,
  output logic [NUM_PINS-1:0] pad_oe_q,
  output logic [NUM_PINS-1:0] pad_pull_up_q,
  output logic [NUM_PINS-1:0] pad_pull_down_q,
  output logic [2*NUM_PINS-1:0] pad_speed_q,
  output logic [NUM_PINS-1:0] pad_analog_q,
  output logic [NUM_PINS-1:0] gpio_in_q,
  output logic [iom_pkg::FUNC_COUNT*NUM_PINS-1:0] func_in_q,
  output logic [NUM_IRQ_LINES-1:0] irq_line_level_q,
  output logic [NUM_IRQ_LINES-1:0] irq_src_invalid_q
);
  localparam int FC = iom_pkg::FUNC_COUNT;

  logic [2*NUM_PINS-1:0] mode_q;
  logic [NUM_PINS-1:0] otype_q;
  logic [2*NUM_PINS-1:0] pull_q;
  logic [2*NUM_PINS-1:0] speed_q;
  logic [4*NUM_PINS-1:0] sel_q;
  logic [4*NUM_IRQ_LINES-1:0] src_q;

  logic [NUM_PINS-1:0] out_d;
  logic [NUM_PINS-1:0] oe_d;
  logic [NUM_PINS-1:0] up_d;
  logic [NUM_PINS-1:0] down_d;
  logic [NUM_PINS-1:0] analog_d;
  logic [NUM_PINS-1:0] gin_d;
  logic [FC*NUM_PINS-1:0] fin_d;
  logic [NUM_IRQ_LINES-1:0] level_d;
  logic [NUM_IRQ_LINES-1:0] invalid_d;

  // Settings sampled on the fast system clock; reset state is input, no pull
  always_ff @(posedge clk or negedge rst_b) begin // RQ1
    if (!rst_b) begin
      mode_q <= {NUM_PINS{iom_pkg::MODE_RESET}};
      otype_q <= {NUM_PINS{iom_pkg::OTYPE_RESET}};
      pull_q <= {NUM_PINS{iom_pkg::PULL_RESET}};
      speed_q <= {NUM_PINS{iom_pkg::SPEED_RESET}};
      sel_q <= {NUM_PINS{iom_pkg::FUNC_SEL_RESET}}; // RQ4
      src_q <= {NUM_IRQ_LINES{iom_pkg::IRQ_SRC_RESET}};
    end else begin
      mode_q <= pin_mode_setting;
      otype_q <= pin_output_type_setting; // RQ9
      pull_q <= pin_pull_setting; // RQ9
      speed_q <= pin_speed_setting; // RQ14
      sel_q <= {func_select_high_half, func_select_low_half}; // RQ3
      src_q <= irq_line_source_select; // RQ11
    end
  end

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    wire [3:0] sel = sel_q[4*i +: 4]; // RQ3
    wire [1:0] mode = mode_q[2*i +: 2];
    wire [1:0] pull = pull_q[2*i +: 2];
    wire alt = (mode == iom_pkg::MODE_ALT); // RQ7
    wire is_sys = (sel == iom_pkg::FUNC_SEL_ZERO);
    wire is_periph = (sel >= iom_pkg::FUNC_SEL_ONE) &&
                     (sel <= iom_pkg::FUNC_SEL_THIRTEEN); // RQ5
    wire is_event = (sel == iom_pkg::FUNC_SEL_FIFTEEN); // RQ6
    // Single indexed pick, so two functions can never share the pin
    wire fval = func_out[FC*i + int'(sel)]; // RQ2 RQ10
    wire foe = func_oe[FC*i + int'(sel)];
    wire src_val = is_event ? core_event_output :
                   (is_sys || is_periph) ? fval : 1'h0; // RQ6
    wire src_oe = is_event ? 1'h1 :
                  (is_sys || is_periph) ? foe : 1'h0; // RQ7
    wire drv_val = alt ? src_val : gpio_out[i];
    wire drv_en = alt ? src_oe : (mode == iom_pkg::MODE_OUTPUT);
    wire od = (otype_q[i] == iom_pkg::OTYPE_OPEN_DRAIN);
    // Open drain only ever pulls low; a high is left to the pull or board
    assign out_d[i] = od ? 1'h0 : drv_val; // RQ13
    assign oe_d[i] = drv_en & (od ? ~drv_val : 1'h1); // RQ13
    assign analog_d[i] = (mode == iom_pkg::MODE_ANALOG); // RQ13
    // Pulls are cut in analog mode to keep the analog path clean
    assign up_d[i] = (pull == iom_pkg::PULL_UP) && !analog_d[i]; // RQ9
    assign down_d[i] = (pull == iom_pkg::PULL_DOWN) && !analog_d[i]; // RQ9
    assign gin_d[i] = analog_d[i] ? 1'h0 : pad_in[i];
    for (genvar f = 0; f < FC; f++) begin : g_fin
      assign fin_d[FC*i + f] = alt && (sel == 4'(f)) &&
        (4'(f) <= iom_pkg::FUNC_SEL_THIRTEEN) && pad_in[i]; // RQ2 RQ5
    end
  end

  for (genvar j = 0; j < NUM_IRQ_LINES; j++) begin : g_irq
    wire [3:0] code = src_q[4*j +: 4];
    wire valid = (code <= iom_pkg::IRQ_PORT_MAX); // RQ12
    wire [2:0] pidx = valid ? code[2:0] : 3'h0;
    assign invalid_d[j] = !valid; // RQ12
    assign level_d[j] = valid && port_pins[NUM_PORTS*j + int'(pidx)]; // RQ11
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pad_out_q <= '0;
      pad_oe_q <= '0;
      pad_pull_up_q <= '0;
      pad_pull_down_q <= '0;
      pad_speed_q <= '0;
      pad_analog_q <= '0;
      gpio_in_q <= '0;
      func_in_q <= '0;
      irq_line_level_q <= '0;
      irq_src_invalid_q <= '0;
    end else begin
      pad_out_q <= out_d;
      pad_oe_q <= oe_d;
      pad_pull_up_q <= up_d;
      pad_pull_down_q <= down_d;
      pad_speed_q <= speed_q; // RQ14
      pad_analog_q <= analog_d;
      gpio_in_q <= gin_d;
      func_in_q <= fin_d;
      irq_line_level_q <= level_d;
      irq_src_invalid_q <= invalid_d;
    end
  end

  // Checks on pin 0 and interrupt line 0, plus every selector at reset and the top pin's high-half selector
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  wire [3:0] sel0 = sel_q[3:0];
  wire alt0 = (mode_q[1:0] == iom_pkg::MODE_ALT);
  wire pp0 = (otype_q[0] == iom_pkg::OTYPE_PUSH_PULL);

  a_sel_reset_zero: assert property ( // RQ4
    $rose(rst_b) |-> (sel_q == '0))
    else $error("selector not zero after reset");
  a_sel_high_half: assert property ( // RQ3
    ##2 (sel_q[4*NUM_PINS-1 -: 4] ==
         $past(func_select_high_half[2*NUM_PINS-1 -: 4], 1)))
    else $error("high half selector field misplaced");
  a_periph_drive: assert property ( // RQ5
    (alt0 && pp0 && sel0 >= 4'h1 && sel0 <= 4'hD) |=>
      (pad_out_q[0] == $past(func_out[sel0]) &&
       pad_oe_q[0] == $past(func_oe[sel0])))
    else $error("peripheral not driving selected pin");
  a_event_route: assert property ( // RQ6
    (alt0 && pp0 && sel0 == 4'hF) |=>
      (pad_oe_q[0] && pad_out_q[0] == $past(core_event_output)))
    else $error("event output not routed");
  a_unused_idle: assert property ( // RQ5
    (alt0 && sel0 == 4'hE) |=> !pad_oe_q[0] && func_in_q[FC-1:0] == '0)
    else $error("selector fourteen drives pin");
  a_single_input: assert property ( // RQ2
    $onehot0(func_in_q[FC-1:0]))
    else $error("pad input reaches several functions");
  a_od_no_high: assert property ( // RQ13
    (otype_q[0] == iom_pkg::OTYPE_OPEN_DRAIN) |=> !pad_out_q[0])
    else $error("open drain drives high");
  a_pull_follow: assert property ( // RQ9
    (pull_q[1:0] == iom_pkg::PULL_UP &&
     mode_q[1:0] != iom_pkg::MODE_ANALOG) |=>
      pad_pull_up_q[0] && !pad_pull_down_q[0])
    else $error("pull up not applied");
  a_irq_invalid: assert property ( // RQ12
    (src_q[3:0] > 4'h5) |=> irq_src_invalid_q[0] && !irq_line_level_q[0])
    else $error("invalid interrupt source accepted");
  a_irq_route: assert property ( // RQ11
    (src_q[3:0] <= 4'h5) |=>
      irq_line_level_q[0] == $past(port_pins[src_q[2:0]]))
    else $error("interrupt line from wrong port");
  a_sys_direction: assert property ( // RQ7
    (alt0 && pp0 && sel0 == iom_pkg::FUNC_SEL_ZERO) |=>
      pad_oe_q[0] == $past(func_oe[0]))
    else $error("system function does not set pin direction");
  a_input_quiet: assert property ( // RQ13
    (mode_q[1:0] == iom_pkg::MODE_INPUT) |=> !pad_oe_q[0])
    else $error("input mode drives the pin");
  a_gpio_drive: assert property ( // RQ13
    (mode_q[1:0] == iom_pkg::MODE_OUTPUT && pp0) |=>
      (pad_oe_q[0] && pad_out_q[0] == $past(gpio_out[0])))
    else $error("output mode not driving pin data");
  a_analog_cut: assert property ( // RQ13
    (mode_q[1:0] == iom_pkg::MODE_ANALOG) |=>
      (pad_analog_q[0] && !pad_oe_q[0] && !gpio_in_q[0] &&
       !pad_pull_up_q[0] && !pad_pull_down_q[0]))
    else $error("analog mode leaves digital path active");

  // Speed is two stages: setting register, then pad register
  sequence s_speed_staged;
    speed_q[1:0] == $past(pin_speed_setting[1:0]);
  endsequence
  sequence s_speed_at_pad;
    pad_speed_q[1:0] == $past(speed_q[1:0]);
  endsequence
  a_speed_path: assert property ( // RQ14
    s_speed_staged ##1 s_speed_at_pad)
    else $error("speed code not passed to pad");
endmodule : iom_io_pin_function_mux

// ==== src/iom_pkg.sv ====
// Constants shared by the pin function multiplexer
package iom_pkg;
  localparam int FUNC_COUNT = 16;
  localparam int SEL_WIDTH = 4;
  localparam logic [1:0] MODE_INPUT = 2'h0;
  localparam logic [1:0] MODE_OUTPUT = 2'h1;
  localparam logic [1:0] MODE_ALT = 2'h2;
  localparam logic [1:0] MODE_ANALOG = 2'h3;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic OTYPE_PUSH_PULL = 1'h0;
  localparam logic OTYPE_OPEN_DRAIN = 1'h1;
  localparam logic OTYPE_RESET = 1'h0;
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_UP = 2'h1;
  localparam logic [1:0] PULL_DOWN = 2'h2;
  localparam logic [1:0] PULL_RESET = 2'h0;
  localparam logic [1:0] SPEED_RESET = 2'h0;
  localparam logic [3:0] FUNC_SEL_ZERO = 4'h0;
  localparam logic [3:0] FUNC_SEL_ONE = 4'h1;
  localparam logic [3:0] FUNC_SEL_THIRTEEN = 4'hD;
  localparam logic [3:0] FUNC_SEL_FIFTEEN = 4'hF;
  localparam logic [3:0] FUNC_SEL_RESET = 4'h0;
  localparam logic [3:0] IRQ_PORT_MAX = 4'h5;
  localparam logic [3:0] IRQ_SRC_RESET = 4'h0;
endpackage : iom_pkg

// ==== verification/iom_far_model.sv ====
// Far-side model: peripherals behind the selectors and the pad wires
`timescale 1ns/1ns
module iom_far_model #(
  parameter int NUM_PINS = 16
) (
  input wire logic [15:0] per_val,
  input wire logic [15:0] per_oe,
  input wire logic [NUM_PINS-1:0] ext_level,
  input wire logic [NUM_PINS-1:0] pad_out_q,
  input wire logic [NUM_PINS-1:0] pad_oe_q,
  input wire logic [NUM_PINS-1:0] pad_pull_up_q,
  input wire logic [NUM_PINS-1:0] pad_pull_down_q,
  output logic [16*NUM_PINS-1:0] func_out,
  output logic [16*NUM_PINS-1:0] func_oe,
  output logic [NUM_PINS-1:0] pad_in
);
  // Same peripheral signal offered on every pin
  assign func_out = {NUM_PINS{per_val}};
  // Peripheral alone decides direction
  assign func_oe = {NUM_PINS{per_oe}};
  // Released pad: pull wins, else the board's own level
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pad_in[i] = pad_oe_q[i] ? pad_out_q[i] : pad_pull_up_q[i] ? 1'h1 :
                  pad_pull_down_q[i] ? 1'h0 : ext_level[i];
    end
  end
endmodule : iom_far_model

// ==== verification/iom_io_pin_function_mux_tb.sv ====
// Self-checking bench for the pin function multiplexer
`timescale 1ns/1ns
module iom_io_pin_function_mux_tb;
  logic clk, rst_b, core_event_output;
  logic [31:0] pin_mode_setting, pin_pull_setting, pin_speed_setting;
  logic [31:0] func_select_low_half, func_select_high_half, pad_speed_q;
  logic [15:0] pin_output_type_setting, gpio_out, pad_in, per_val, per_oe;
  logic [15:0] ext_level, pad_out_q, pad_oe_q, pad_pull_up_q;
  logic [15:0] pad_pull_down_q, pad_analog_q, gpio_in_q;
  logic [15:0] irq_line_level_q, irq_src_invalid_q;
  logic [255:0] func_out, func_oe, func_in_q;
  logic [63:0] irq_line_source_select;
  logic [95:0] port_pins;
  int n_mismatch = 0;
  int checks_done = 0;

  iom_io_pin_function_mux DUT (.clk, .rst_b, .pin_mode_setting,
    .pin_output_type_setting, .pin_pull_setting, .pin_speed_setting,
    .func_select_low_half, .func_select_high_half, .gpio_out, .func_out,
    .func_oe, .core_event_output, .pad_in, .irq_line_source_select,
    .port_pins, .pad_out_q, .pad_oe_q, .pad_pull_up_q, .pad_pull_down_q,
    .pad_speed_q, .pad_analog_q, .gpio_in_q, .func_in_q, .irq_line_level_q,
    .irq_src_invalid_q);
  iom_far_model u_far (.per_val, .per_oe, .ext_level, .pad_out_q, .pad_oe_q,
    .pad_pull_up_q, .pad_pull_down_q, .func_out, .func_oe, .pad_in);

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : step

  task automatic t_reset();
    step(1);
    check(pad_oe_q | func_in_q[15:0], 16'h0000);
    per_val = 16'h0001;
    per_oe = 16'h0001;
    pin_mode_setting[1:0] = iom_pkg::MODE_ALT;
    step(3);
    // Selector never written, so input zero must be live
    check(16'({pad_oe_q[0], pad_out_q[0]}), 16'h0003);
  endtask : t_reset

  task automatic t_alt();
    logic eo, ev, pin;
    logic [15:0] fin;
    logic [15:0] got;
    per_val = 16'hA5C3;
    per_oe = 16'h3C5A;
    core_event_output = 1'h1;
    pin_mode_setting[19:18] = iom_pkg::MODE_ALT;
    step(3);
    for (int f = 0; f < 16; f++) begin
      func_select_low_half[3:0] = f[3:0];
      func_select_high_half[7:4] = f[3:0];
      step(4);
      eo = (f <= 13) ? per_oe[f] : (f == 15);
      ev = (f <= 13) ? per_val[f] : core_event_output;
      pin = eo ? ev : ext_level[0];
      fin = (f <= 13) ? 16'(pin) << f : 16'h0000;
      got = 16'({pad_oe_q[9], pad_oe_q[0], pad_out_q[0] & eo});
      check(got, 16'({eo, eo, ev & eo}));
      check(func_in_q[15:0], fin);
      check(func_in_q[159:144], fin);
    end
  endtask : t_alt

  task automatic t_drive();
    logic [15:0] got;
    per_oe = 16'hFFFF;
    pin_output_type_setting[0] = iom_pkg::OTYPE_OPEN_DRAIN;
    step(1);
    func_select_low_half[3:0] = iom_pkg::FUNC_SEL_ONE;
    for (int k = 0; k < 4; k++) begin
      per_val[1] = k[0];
      pin_pull_setting[1:0] = k[1:0];
      pin_speed_setting[1:0] = k[1:0];
      step(4);
      got = 16'({pad_speed_q[1:0], pad_pull_down_q[0], pad_pull_up_q[0],
                 pad_oe_q[0], pad_out_q[0]});
      check(got, 16'({k[1:0], k == 2, k == 1, ~k[0], 1'h0}));
    end
    pin_output_type_setting[0] = iom_pkg::OTYPE_PUSH_PULL;
    pin_mode_setting[1:0] = iom_pkg::MODE_OUTPUT;
    gpio_out[0] = 1'h1;
    step(4);
    // Driven pad must also read back on the digital input
    check(16'({pad_oe_q[0], pad_out_q[0], gpio_in_q[0]}), 16'h0007);
    pin_pull_setting[1:0] = iom_pkg::PULL_UP;
    pin_mode_setting[1:0] = iom_pkg::MODE_ANALOG;
    step(4);
    // Analog must cut both the pull and the digital input
    got = 16'({pad_analog_q[0], pad_pull_up_q[0], gpio_in_q[0]});
    check(got, 16'h0004);
  endtask : t_drive

  task automatic t_irq();
    logic [15:0] got;
    for (int c = 0; c < 16; c++) begin
      irq_line_source_select[3:0] = c[3:0];
      port_pins[5:0] = 6'h2A ^ {6{c[0]}};
      step(3);
      got = 16'({irq_src_invalid_q[0], irq_line_level_q[0]});
      check(got, 16'({c > 5, c <= 5 && port_pins[c % 6]}));
    end
  endtask : t_irq

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (1000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end

  initial begin
    {rst_b, core_event_output, pin_mode_setting, pin_pull_setting} = '0;
    {pin_speed_setting, func_select_low_half, func_select_high_half} = '0;
    {pin_output_type_setting, gpio_out, per_val, per_oe} = '0;
    {irq_line_source_select, port_pins} = '0;
    ext_level = 16'hFFFF;
    repeat (3) @(posedge clk);
    #10 rst_b = 1'h1;
    t_reset();
    t_alt();
    t_drive();
    t_irq();
    finish_test();
  end
endmodule : iom_io_pin_function_mux_tb
